// *** sim/spcs_props.sv ***
// Purpose: port checks for spcs_top
// Assumes: one clock, async low reset
// Notes:   bound to the top after endmodule
module spcs_chk (
    input wire logic        I_CLK,
    input wire logic        I_RST_N,
    input wire logic [3:0]  I_SA6_CODE,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [13:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic        O_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] m_now, m_prv;
    logic [7:0] en_seen;
    logic       ev, rd, rd_fl, rd_en, en_wr;
    // match vector; lsb ignored for the 2or3 code
    assign m_now = {I_SA6_CODE == 4'hF, I_SA6_CODE == 4'hE, I_SA6_CODE == 4'hC,
                    I_SA6_CODE == 4'hA, I_SA6_CODE == 4'h8, I_SA6_CODE[3:1] == 3'h1};
    assign ev    = m_now != m_prv;
    assign rd    = I_PSEL & I_PENABLE & !I_PWRITE;
    assign rd_fl = rd & (I_PADDR == spcs_pkg::FLAGS_ADDR);
    assign rd_en = rd & (I_PADDR == spcs_pkg::ENABLES_ADDR);
    assign en_wr = I_PSEL & I_PENABLE & I_PWRITE & (I_PADDR == spcs_pkg::ENABLES_ADDR);
    // previous match resets to no match, as the matchers do
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            m_prv   <= 6'h0;
            en_seen <= 8'h00;
        end else begin
            m_prv <= m_now;
            if (en_wr) en_seen <= I_PWDATA[7:0] & 8'hFC;
        end
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    chk_ready_on: assert property (O_PREADY) else $error("pready low");
    chk_no_err: assert property (!O_PSLVERR) else $error("pslverr high");
    chk_pad_zero: assert property (rd |-> O_PRDATA[31:8] == 24'h0 && O_PRDATA[1:0] == 2'h0)
        else $error("unused read bits set");
    chk_unmapped_zero: assert property (rd && !rd_fl && !rd_en |-> O_PRDATA == 32'h0)
        else $error("unmapped read not zero");
    chk_irq_rise: assert property ($rose(O_IRQ) |-> $past(ev) || $past(en_wr))
        else $error("irq rose without cause");
    chk_irq_fall: assert property ($fell(O_IRQ) |-> $past(rd_fl) || $past(en_wr))
        else $error("irq fell without read");
    chk_read_clear: assert property (rd_fl && !ev |=> !O_IRQ) else $error("read left irq");
    chk_en_back: assert property (rd_en |-> O_PRDATA == {24'h0, en_seen})
        else $error("enable readback wrong");
    cover property (rd_fl && ev);
    cover property ($rose(O_IRQ));
    cover property (en_wr);
endmodule : spcs_chk

bind spcs_top spcs_chk u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SA6_CODE(I_SA6_CODE),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_IRQ(O_IRQ));

// *** sim/spcs_top_tb.sv ***
// Purpose: self-checking bench for spcs_top
// Assumes: apb with no wait states, code on the same clock
// Notes:   random codes ride along with apb accesses
module spcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] FA = spcs_pkg::FLAGS_ADDR;
    localparam logic [13:0] EA = spcs_pkg::ENABLES_ADDR;
    logic        clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0, ready, err, irq;
    logic [3:0]  code = 4'h0, pc = 4'h0;
    logic [13:0] adr = 14'h0;
    logic [31:0] wd = 32'h0, rdata;
    logic [7:0]  exp_f = 8'h00, exp_e = 8'h00;
    int          n_mismatch = 0, checks_done = 0, seed = 32'h97D9, i, op;

    spcs_top uut (.I_CLK(clk), .I_RST_N(rst_n), .I_SA6_CODE(code), .I_PSEL(sel),
        .I_PENABLE(en), .I_PWRITE(wr), .I_PADDR(adr), .I_PWDATA(wd), .O_PRDATA(rdata),
        .O_PREADY(ready), .O_PSLVERR(err), .O_IRQ(irq));

    initial forever #2 clk = ~clk;
    // ---------------------------------------------------------------
    // model and bus tasks
    // ---------------------------------------------------------------
    function automatic logic [7:0] mt(input logic [3:0] c);
        mt = {c == 4'hF, c == 4'hE, c == 4'hC, c == 4'hA, c == 4'h8, c[3:1] == 3'h1, 2'h0};
    endfunction : mt
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    // code moves in the access cycle, so a read can race an event
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] c);
        int k;
        logic [31:0] x;
        x = (a == FA) ? {24'h0, exp_f} : (a == EA) ? {24'h0, exp_e} : 32'h0;
        @(posedge clk);
        {sel, en, wr, adr, wd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        en <= 1'b1;
        code <= c;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ready !== 1'b1 && k < 20);
        if (!w) chk("prdata", rdata, x);
        chk("pslverr", {31'h0, err}, 32'h0);
        sel <= 1'b0;
        en <= 1'b0;
        exp_f = (!w && a == FA) ? mt(pc) ^ mt(c) : exp_f | mt(pc) ^ mt(c); // set beats clear
        pc = c;
        if (w && a == EA) exp_e = d[7:0] & 8'hFC;
    endtask : apb
    task automatic step(input logic [3:0] c);
        @(posedge clk);
        code <= c;
        @(posedge clk);
        #1;
        exp_f |= mt(pc) ^ mt(c);
        pc = c;
        chk("irq", irq, |(exp_f & exp_e));
    endtask : step
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // watchdog far beyond the roughly one thousand cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, EA, 0, 0);
        apb(0, FA, 0, 0);
        apb(1, FA, 32'hFF, 0);
        apb(0, 14'h4, 0, 0);
        $display("reset test done");
        apb(1, EA, 32'hFFFFFFFF, 0);
        for (i = 0; i < 16; i++) begin
            step(i[3:0]);
            step(4'h0);
            apb(0, FA, 0, 0);
        end
        $display("pattern test done");
        for (i = 0; i < 300; i++) begin
            op = $random(seed) & 3;
            case (op)
                0: apb(0, FA, 0, $random(seed));
                1: apb(1, EA, $random(seed), $random(seed));
                2: apb(0, EA, 0, $random(seed));
                default: step($random(seed));
            endcase
        end
        $display("random test done");
        print_verdict;
    end
endmodule : spcs_top_tb

// *** src/spcs_edge.sv ***
// Purpose: one pattern matcher with change pulse
// Assumes: code is on the same clock
// Notes:   care mask lets a bit be ignored
module spcs_edge #(
    parameter logic [3:0] PATTERN = 4'h0,
    parameter logic [3:0] CARE    = 4'hF
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_code,
    output logic            o_change
);
    typedef struct packed {
        logic match_r;
    } spcs_edge_st_t;

    spcs_edge_st_t st_r;
    spcs_edge_st_t st_nxt;
    logic          match;

    // ---------------------------------------------------------------
    // matcher
    // ---------------------------------------------------------------
    // R12: previous cycle compare
    always_comb begin
        match          = ((i_code ^ PATTERN) & CARE) == 4'h0;
        st_nxt.match_r = match;
        o_change       = match ^ st_r.match_r;  // both directions
    end

    // reset value is no match, so a code sitting at reset gives one pulse
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : spcs_edge

// *** src/spcs_pkg.sv ***
// Purpose: constants for the spare-bit pattern change status block
// Assumes: apb slave, 32-bit data, one word per register
// Notes:   flags are sticky and clear when software reads them
//
// Overview of operation
// R1: bit 7 toggles event on code 1111
// R2: bit 6 toggles event on code 1110
// R3: bit 5 toggles event on code 1100
// R4: bit 4 toggles event on code 1010
// R5: bit 3 toggles event on code 1000
// R6: bit 2 event on 001x, lsb ignored
// R7: flags sticky until read clears them
// R8: one means event since last read; an event in the setup cycle of a flags read is cleared without being read
// R9: interrupt only for enabled events
// R10: enable register at next address, reset zero
// R11: new event beats same-cycle read clear
// R12: compare match with previous cycle value
package spcs_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [11:0] FLAGS_IDX   = 12'hB0C;
    localparam logic [11:0] ENABLES_IDX = 12'hB0D;
    localparam int          ADDR_W      = 14;
    localparam logic [13:0] FLAGS_ADDR   = {FLAGS_IDX, 2'h0};
    localparam logic [13:0] ENABLES_ADDR = {ENABLES_IDX, 2'h0};
    localparam int          REG_W       = 8;
    localparam logic [7:0]  FLAGS_RST   = 8'h00;
    localparam logic [7:0]  ENABLES_RST = 8'h00;
    localparam logic [7:0]  USED_MASK   = 8'hFC;
    // ---------------------------------------------------------------
    // patterns, bit position equals index
    // ---------------------------------------------------------------
    localparam int          CODE_W      = 4;
    localparam int          FIRST_BIT   = 2;
    localparam int          LAST_BIT    = 7;
    localparam logic [3:0]  PAT_ALL1    = 4'hF;
    localparam logic [3:0]  PAT_E       = 4'hE;
    localparam logic [3:0]  PAT_C       = 4'hC;
    localparam logic [3:0]  PAT_A       = 4'hA;
    localparam logic [3:0]  PAT_8       = 4'h8;
    localparam logic [3:0]  PAT_2       = 4'h2;
    localparam logic [3:0]  CARE_ALL    = 4'hF;
    localparam logic [3:0]  CARE_NO_LSB = 4'hE;
endpackage : spcs_pkg

// *** src/spcs_top.sv ***
// Purpose: spare-bit pattern change flags with interrupt
// Assumes: debounced code comes from logic on I_CLK
// Notes:   apb answers with no wait states
//
// Register access over APB was left to the implementer.
module spcs_top (
    input  wire logic                     I_CLK,
    input  wire logic                     I_RST_N,
    input  wire logic [3:0]               I_SA6_CODE,
    input  wire logic                     I_PSEL,
    input  wire logic                     I_PENABLE,
    input  wire logic                     I_PWRITE,
    input  wire logic [13:0]              I_PADDR,
    input  wire logic [31:0]              I_PWDATA,
    output logic      [31:0]              O_PRDATA,
    output logic                          O_PREADY,
    output logic                          O_PSLVERR,
    output logic                          O_IRQ
);
    typedef struct packed {
        logic [7:0]  flags_r;
        logic [7:0]  enables_r;
        logic [31:0] rdata_r;
        logic        irq_r;
    } spcs_state_t;

    spcs_state_t st_r;
    spcs_state_t st_nxt;
    logic [7:0]  event_vec;
    logic        access;
    logic        hit_flags;
    logic        hit_enables;

    // ---------------------------------------------------------------
    // pattern matchers
    // ---------------------------------------------------------------
    // R1: all ones watch
    spcs_edge #(.PATTERN(spcs_pkg::PAT_ALL1), .CARE(spcs_pkg::CARE_ALL)) u_p7 (
        .i_clk    (I_CLK),
        .i_rst_n  (I_RST_N),
        .i_code   (I_SA6_CODE),
        .o_change (event_vec[7])
    );
    // R2: code e watch
    spcs_edge #(.PATTERN(spcs_pkg::PAT_E), .CARE(spcs_pkg::CARE_ALL)) u_p6 (
        .i_clk    (I_CLK),
        .i_rst_n  (I_RST_N),
        .i_code   (I_SA6_CODE),
        .o_change (event_vec[6])
    );
    // R3: code c watch
    spcs_edge #(.PATTERN(spcs_pkg::PAT_C), .CARE(spcs_pkg::CARE_ALL)) u_p5 (
        .i_clk    (I_CLK),
        .i_rst_n  (I_RST_N),
        .i_code   (I_SA6_CODE),
        .o_change (event_vec[5])
    );
    // R4: code a watch
    spcs_edge #(.PATTERN(spcs_pkg::PAT_A), .CARE(spcs_pkg::CARE_ALL)) u_p4 (
        .i_clk    (I_CLK),
        .i_rst_n  (I_RST_N),
        .i_code   (I_SA6_CODE),
        .o_change (event_vec[4])
    );
    // R5: code 8 watch
    spcs_edge #(.PATTERN(spcs_pkg::PAT_8), .CARE(spcs_pkg::CARE_ALL)) u_p3 (
        .i_clk    (I_CLK),
        .i_rst_n  (I_RST_N),
        .i_code   (I_SA6_CODE),
        .o_change (event_vec[3])
    );
    // R6: lsb ignored here
    spcs_edge #(.PATTERN(spcs_pkg::PAT_2), .CARE(spcs_pkg::CARE_NO_LSB)) u_p2 (
        .i_clk    (I_CLK),
        .i_rst_n  (I_RST_N),
        .i_code   (I_SA6_CODE),
        .o_change (event_vec[2])
    );
    // bits 1-0 belong to other logic and never fire here
    assign event_vec[1:0] = 2'h0;

    // ---------------------------------------------------------------
    // apb decode, zero wait states
    // ---------------------------------------------------------------
    assign access      = I_PSEL & I_PENABLE;
    assign hit_flags   = I_PADDR == spcs_pkg::FLAGS_ADDR;
    assign hit_enables = I_PADDR == spcs_pkg::ENABLES_ADDR;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // read data captured in setup so it is stable in access phase
        if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            if (hit_flags) begin
                st_nxt.rdata_r = {24'h0, st_r.flags_r};
            end else if (hit_enables) begin
                st_nxt.rdata_r = {24'h0, st_r.enables_r};
            end else begin
                st_nxt.rdata_r = 32'h0;
            end
        end
        // R7: read clears flags
        if (access && !I_PWRITE && hit_flags) begin
            st_nxt.flags_r = spcs_pkg::FLAGS_RST;
        end
        // R11: set beats clear
        // R8: one marks event
        st_nxt.flags_r = st_nxt.flags_r | (event_vec & spcs_pkg::USED_MASK);
        // R10: enable register write
        if (access && I_PWRITE && hit_enables) begin
            st_nxt.enables_r = I_PWDATA[7:0] & spcs_pkg::USED_MASK;
        end
        // R9: enabled flags only
        st_nxt.irq_r = |(st_nxt.flags_r & st_nxt.enables_r);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_r.flags_r   <= spcs_pkg::FLAGS_RST;
            st_r.enables_r <= spcs_pkg::ENABLES_RST;
            st_r.rdata_r   <= 32'h0;
            st_r.irq_r     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign O_PRDATA  = st_r.rdata_r;
    assign O_PREADY  = 1'b1;   // never stalls
    assign O_PSLVERR = 1'b0;   // unmapped reads zero, writes dropped
    assign O_IRQ     = st_r.irq_r;
endmodule : spcs_top
